// [core/aluex_core.sv]
// aluex_core: executes alu, compare, skip, branch, call and return instructions
// with its own working registers, status flags, program counter and return stack.
// assumes one Avalon-MM master on ref_clk; writes wait while an instruction runs.
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module aluex_core #(
	parameter int PC_W      = 9,
	parameter int STK_DEPTH = 3
) (
	input  logic                         ref_clk,
	input  logic                         rst,
	input  logic [aluex_pkg::ADDR_W-1:0] avs_address,
	input  logic                         avs_read,
	input  logic                         avs_write,
	input  logic [31:0]                  avs_writedata,
	input  logic [3:0]                   avs_byteenable,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest
);
	import aluex_pkg::*;

	localparam int SP_W = (STK_DEPTH > 1) ? $clog2(STK_DEPTH) : 1;

	typedef enum logic {ST_IDLE, ST_EXEC} aluex_state_t;

	aluex_state_t   state_r;
	logic [2:0]     busyCnt_r;
	logic [2:0]     lastCyc_r;
	logic           lastJump_r;
	logic [7:0]     wreg_r [32];
	logic [7:0]     flags_r;
	logic [PC_W-1:0] pc_r;
	logic [7:0]     ioBits_r;
	logic [PC_W-1:0] stack_r [STK_DEPTH];
	logic [SP_W-1:0] sp_r;
	logic           rdValid_r;
	logic [31:0]    readData_r;
	logic [31:0]    rdMux;
	aluex_instr_t   instr;
	aluex_alu_in_t  aluIn;
	aluex_alu_out_t aluOut;
	logic [7:0]     aVal;
	logic [7:0]     rVal;
	logic           wrTake;
	logic           wrOk;
	logic           exec;
	logic           wregHit;
	logic [4:0]     wIdx;
	logic [PC_W-1:0] pc1;
	logic [PC_W-1:0] pcNxt;
	logic [PC_W-1:0] stackTop;
	logic [2:0]     cycNxt;
	logic           push;
	logic           pop;
	logic           setI;
	logic           skip;
	logic           jump;
	logic [1:0]     br;

	// stack pointer steps wrap at the depth, so a deep nest overwrites the oldest
	function automatic logic [SP_W-1:0] spStep(input logic [SP_W-1:0] sp, input logic up);
		if (up)
			return (sp == SP_W'(STK_DEPTH - 1)) ? '0 : sp + 1'b1;
		return (sp == '0) ? SP_W'(STK_DEPTH - 1) : sp - 1'b1;
	endfunction : spStep

	// pc plus signed 12-bit offset plus one, cut to the pc width
	function automatic logic [PC_W-1:0] relTarget(input logic [PC_W-1:0] pc, input logic [11:0] k);
		logic [15:0] t;
		t = 16'(pc) + {{4{k[11]}}, k} + 16'h0001;
		return t[PC_W-1:0];
	endfunction : relTarget

	// returns {is a branch, condition met}
	function automatic logic [1:0] brDecode(input aluex_op_t op, input logic [7:0] f, input logic [2:0] s);
		case (op)
			OP_BRANCH_FLAG_SET:     return {1'b1, f[s]};
			OP_BRANCH_FLAG_CLEAR:   return {1'b1, ~f[s]};
			OP_BRANCH_EQUAL:        return {1'b1, f[FLG_Z]};
			OP_BRANCH_NOT_EQUAL:    return {1'b1, ~f[FLG_Z]};
			OP_BRANCH_CARRY_SET,
			OP_BRANCH_LOWER:        return {1'b1, f[FLG_C]};
			OP_BRANCH_CARRY_CLEAR,
			OP_BRANCH_SAME_HIGHER:  return {1'b1, ~f[FLG_C]};
			OP_BRANCH_MINUS:        return {1'b1, f[FLG_N]};
			OP_BRANCH_PLUS:         return {1'b1, ~f[FLG_N]};
			OP_BRANCH_SIGNED_GE:    return {1'b1, ~(f[FLG_N] ^ f[FLG_V])};
			OP_BRANCH_SIGNED_LT:    return {1'b1, f[FLG_N] ^ f[FLG_V]};
			OP_BRANCH_HALF_SET:     return {1'b1, f[FLG_H]};
			OP_BRANCH_HALF_CLEAR:   return {1'b1, ~f[FLG_H]};
			OP_BRANCH_TBIT_SET:     return {1'b1, f[FLG_T]};
			OP_BRANCH_TBIT_CLEAR:   return {1'b1, ~f[FLG_T]};
			OP_BRANCH_OVF_SET:      return {1'b1, f[FLG_V]};
			OP_BRANCH_OVF_CLEAR:    return {1'b1, ~f[FLG_V]};
			OP_BRANCH_IRQ_ON:       return {1'b1, f[FLG_I]};
			OP_BRANCH_IRQ_OFF:      return {1'b1, ~f[FLG_I]};
			default:                return 2'b00;
		endcase
	endfunction : brDecode

	// bus decode: writes stall while a multi-cycle instruction is in flight
	assign wrTake = avs_write & (state_r == ST_IDLE);
	assign wrOk = wrTake & (avs_byteenable == BE_ALL);
	assign exec = wrOk & (avs_address == REG_INSTR);
	assign wregHit = ((avs_address & ~WREG_SPAN) == REG_WREG_BASE);
	assign wIdx = avs_address[6:2];
	assign avs_waitrequest = (avs_read & ~rdValid_r) | (avs_write & (state_r != ST_IDLE));
	assign avs_readdata = readData_r;

	// operand fetch straight from the instruction word being written
	assign instr = aluex_instr_t'(avs_writedata);
	assign aVal = wreg_r[instr.rd];
	assign rVal = wreg_r[instr.rr];
	assign pc1 = pc_r + 1'b1;
	assign stackTop = stack_r[spStep(sp_r, 1'b0)];

	// immediate forms take the low byte of k as their second operand
	always_comb begin
		aluIn.op = instr.op;
		aluIn.a = aVal;
		aluIn.flags = flags_r;
		aluIn.b = rVal;
		if (instr.op inside {OP_SUB_CONST, OP_SUB_CARRY_CONST, OP_AND_CONST, OP_OR_CONST,
				OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_COMPARE_IMMEDIATE})
			aluIn.b = instr.k[7:0];
	end

	aluex_alu u_alu (
		.aluIn  (aluIn),
		.aluOut (aluOut)
	);

	// program counter flow and cycle count of the instruction
	always_comb begin
		br = brDecode(instr.op, flags_r, instr.bitSel);
		pcNxt = pc1;
		cycNxt = CYC_SINGLE;
		push = 1'b0;
		pop = 1'b0;
		setI = 1'b0;
		skip = 1'b0;
		jump = 1'b0;
		case (instr.op)
			OP_REL_JUMP: begin
				pcNxt = relTarget(pc_r, instr.k);
				cycNxt = CYC_TAKEN;
				jump = 1'b1;
			end
			OP_REL_CALL: begin
				pcNxt = relTarget(pc_r, instr.k);
				cycNxt = CYC_CALL;
				push = 1'b1;
				jump = 1'b1;
			end
			OP_CALL_EXIT, OP_IRQ_EXIT: begin
				pcNxt = stackTop;
				cycNxt = CYC_RETURN;
				pop = 1'b1;
				setI = (instr.op == OP_IRQ_EXIT);
				jump = 1'b1;
			end
			OP_COMPARE_SKIP_EQ:    skip = (aVal == rVal);
			OP_SKIP_REG_BIT_CLEAR: skip = ~rVal[instr.bitSel];
			OP_SKIP_REG_BIT_SET:   skip = rVal[instr.bitSel];
			OP_SKIP_IO_BIT_CLEAR:  skip = ~ioBits_r[instr.bitSel];
			OP_SKIP_IO_BIT_SET:    skip = ioBits_r[instr.bitSel];
			default: begin
				if (br[1] & br[0]) begin
					pcNxt = relTarget(pc_r, instr.k);
					cycNxt = CYC_TAKEN;
					jump = 1'b1;
				end
			end
		endcase
		// a skip steps over exactly one single-word instruction
		if (skip) begin
			pcNxt = pc_r + PC_W'(2);
			cycNxt = CYC_TAKEN;
			jump = 1'b1;
		end
	end

	// sequencer: holds bus writes off for the extra cycles of the instruction
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			busyCnt_r <= 3'h0;
			lastCyc_r <= 3'h0;
			lastJump_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (exec) begin
						lastCyc_r <= cycNxt;
						lastJump_r <= jump;
						if (cycNxt != CYC_SINGLE) begin
							state_r <= ST_EXEC;
							busyCnt_r <= cycNxt - 3'h1;
						end
					end
				end
				ST_EXEC: begin
					busyCnt_r <= busyCnt_r - 3'h1;
					if (busyCnt_r == 3'h1)
						state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// working registers: alu writeback or direct bus write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 32; i++)
				wreg_r[i] <= WREG_RST;
		end else if (exec & aluOut.wb) begin
			wreg_r[instr.rd] <= aluOut.res;
		end else if (wrOk & wregHit) begin
			wreg_r[wIdx] <= avs_writedata[7:0];
		end
	end

	// status flags: instruction result wins over nothing, bus write otherwise
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flags_r <= FLAGS_RST;
		end else if (exec) begin
			flags_r <= aluOut.flags;
			if (setI)
				flags_r[FLG_I] <= 1'b1;
		end else if (wrOk & (avs_address == REG_FLAGS)) begin
			flags_r <= avs_writedata[7:0];
		end
	end

	// program counter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			pc_r <= PC_RST[PC_W-1:0];
		else if (exec)
			pc_r <= pcNxt;
		else if (wrOk & (avs_address == REG_PC))
			pc_r <= avs_writedata[PC_W-1:0];
	end

	// io byte tested by the io bit skips
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			ioBits_r <= IOBITS_RST;
		else if (wrOk & (avs_address == REG_IOBITS))
			ioBits_r <= avs_writedata[7:0];
	end

	// return stack: call pushes the next pc, returns pop, a bus write pushes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < STK_DEPTH; i++)
				stack_r[i] <= PC_RST[PC_W-1:0];
			sp_r <= '0;
		end else if (exec & push) begin
			stack_r[sp_r] <= pc1;
			sp_r <= spStep(sp_r, 1'b1);
		end else if (exec & pop) begin
			sp_r <= spStep(sp_r, 1'b0);
		end else if (wrOk & (avs_address == REG_STACK)) begin
			stack_r[sp_r] <= avs_writedata[PC_W-1:0];
			sp_r <= spStep(sp_r, 1'b1);
		end
	end

	// read mux; unmapped and write-only addresses read as zero
	always_comb begin
		rdMux = 32'h0000_0000;
		if (wregHit) begin
			rdMux[7:0] = wreg_r[wIdx];
		end else begin
			case (avs_address)
				REG_FLAGS:  rdMux[7:0] = flags_r;
				REG_PC:     rdMux[PC_W-1:0] = pc_r;
				REG_IOBITS: rdMux[7:0] = ioBits_r;
				REG_STACK:  rdMux[PC_W-1:0] = stackTop;
				REG_EXEC:   rdMux[4:0] = {lastJump_r, lastCyc_r, state_r == ST_EXEC};
				default:    rdMux = 32'h0000_0000;
			endcase
		end
	end

	// reads take two cycles so that read data always comes from a flop
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdValid_r <= 1'b0;
			readData_r <= 32'h0000_0000;
		end else begin
			rdValid_r <= avs_read & ~rdValid_r;
			if (avs_read & ~rdValid_r)
				readData_r <= rdMux;
		end
	end
endmodule : aluex_core

// [core/aluex_pkg.sv]
// aluex_pkg: register map, instruction word layout, opcodes and alu carriers
// of the alu and branch execution block.
// assumes one core clock and an Avalon-MM master that drives the register port.
package aluex_pkg;
	localparam int         ADDR_W        = 9;
	// byte addresses of the register port
	localparam logic [8:0] REG_INSTR     = 9'h000;
	localparam logic [8:0] REG_FLAGS     = 9'h004;
	localparam logic [8:0] REG_PC        = 9'h008;
	localparam logic [8:0] REG_IOBITS    = 9'h00C;
	localparam logic [8:0] REG_STACK     = 9'h010;
	localparam logic [8:0] REG_EXEC      = 9'h014;
	localparam logic [8:0] REG_WREG_BASE = 9'h100;
	localparam logic [8:0] WREG_SPAN     = 9'h07C;
	localparam logic [3:0] BE_ALL        = 4'hF;
	// status_flags bit positions
	localparam int         FLG_C         = 0;
	localparam int         FLG_Z         = 1;
	localparam int         FLG_N         = 2;
	localparam int         FLG_V         = 3;
	localparam int         FLG_S         = 4;
	localparam int         FLG_H         = 5;
	localparam int         FLG_T         = 6;
	localparam int         FLG_I         = 7;
	// reset values, and the all-ones alu mask
	localparam logic [7:0]  FLAGS_RST    = 8'h00;
	localparam logic [7:0]  IOBITS_RST   = 8'h00;
	localparam logic [7:0]  WREG_RST     = 8'h00;
	localparam logic [11:0] PC_RST       = 12'h000;
	localparam logic [7:0]  MASK_ALL     = 8'hFF;
	// clock cycles per instruction class
	localparam logic [2:0]  CYC_SINGLE   = 3'h1;
	localparam logic [2:0]  CYC_TAKEN    = 3'h2;
	localparam logic [2:0]  CYC_CALL     = 3'h3;
	localparam logic [2:0]  CYC_RETURN   = 3'h4;

	// opcode numbers follow the order of this list, from 0
	typedef enum logic [5:0] {
		OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_CONST, OP_SUB_CARRY, OP_SUB_CARRY_CONST,
		OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST, OP_XOR_REGS, OP_INVERT_BITS,
		OP_TWOS_COMP, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_COUNT_UP, OP_COUNT_DOWN,
		OP_ZERO_MINUS_PROBE, OP_ZERO_REG, OP_FILL_ONES, OP_COMPARE_REGS,
		OP_COMPARE_WITH_CARRY_IN, OP_COMPARE_IMMEDIATE, OP_REL_JUMP, OP_REL_CALL,
		OP_CALL_EXIT, OP_IRQ_EXIT, OP_COMPARE_SKIP_EQ, OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
		OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
		OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER,
		OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
		OP_BRANCH_HALF_SET, OP_BRANCH_HALF_CLEAR, OP_BRANCH_TBIT_SET, OP_BRANCH_TBIT_CLEAR,
		OP_BRANCH_OVF_SET, OP_BRANCH_OVF_CLEAR, OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF
	} aluex_op_t;

	// instruction word written to REG_INSTR, msb first
	typedef struct packed {
		logic        spare;
		logic [2:0]  bitSel;
		logic [11:0] k;
		logic [4:0]  rr;
		logic [4:0]  rd;
		aluex_op_t   op;
	} aluex_instr_t;

	typedef struct packed {
		aluex_op_t  op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] flags;
	} aluex_alu_in_t;

	typedef struct packed {
		logic [7:0] res;
		logic [7:0] flags;
		logic       wb;
	} aluex_alu_out_t;
endpackage : aluex_pkg

// [core/aluex_alu.sv]
// aluex_alu: combinational 8-bit alu with status flag update.
// assumes the caller picks register or immediate operand and commits results.
`timescale 1ns/1ns
module aluex_alu (
	input  aluex_pkg::aluex_alu_in_t  aluIn,
	output aluex_pkg::aluex_alu_out_t aluOut
);
	import aluex_pkg::*;

	// one adder serves add, subtract, compare and negate
	always_comb begin
		logic [7:0] x;
		logic [7:0] y;
		logic [7:0] r;
		logic [7:0] f;
		logic [8:0] wide;
		logic [4:0] nib;
		logic       cin;
		logic       arith;
		logic       sub;
		logic       keepZ;
		logic       logicF;
		logic       vNew;
		logic       wb;
		x = aluIn.a;
		y = aluIn.b;
		r = aluIn.a;
		f = aluIn.flags;
		wide = 9'h000;
		nib = 5'h00;
		cin = 1'b0;
		arith = 1'b0;
		sub = 1'b0;
		keepZ = 1'b0;
		logicF = 1'b0;
		vNew = 1'b0;
		wb = 1'b1;
		case (aluIn.op)
			OP_ADD: arith = 1'b1;
			OP_ADD_CARRY: begin
				arith = 1'b1;
				cin = f[FLG_C];
			end
			OP_SUB, OP_SUB_CONST: begin
				arith = 1'b1;
				sub = 1'b1;
			end
			OP_SUB_CARRY, OP_SUB_CARRY_CONST, OP_COMPARE_WITH_CARRY_IN: begin
				arith = 1'b1;
				sub = 1'b1;
				cin = f[FLG_C];
				keepZ = 1'b1; // zero only stays set across a multi-byte chain
				wb = (aluIn.op != OP_COMPARE_WITH_CARRY_IN);
			end
			OP_COMPARE_REGS, OP_COMPARE_IMMEDIATE: begin
				arith = 1'b1;
				sub = 1'b1;
				wb = 1'b0;
			end
			OP_TWOS_COMP: begin
				arith = 1'b1;
				sub = 1'b1;
				x = 8'h00;
				y = aluIn.a;
			end
			OP_AND, OP_AND_CONST: begin
				logicF = 1'b1;
				r = x & y;
			end
			OP_OR, OP_OR_CONST, OP_SET_MASK_BITS: begin
				logicF = 1'b1;
				r = x | y;
			end
			OP_CLEAR_MASK_BITS: begin
				logicF = 1'b1;
				r = x & (MASK_ALL - y);
			end
			OP_XOR_REGS, OP_ZERO_REG: begin
				logicF = 1'b1;
				r = x ^ ((aluIn.op == OP_ZERO_REG) ? x : y);
			end
			OP_ZERO_MINUS_PROBE: begin
				logicF = 1'b1;
				r = x & x;
			end
			OP_INVERT_BITS: begin
				logicF = 1'b1;
				r = MASK_ALL - x;
				f[FLG_C] = 1'b1;
			end
			OP_COUNT_UP: begin
				logicF = 1'b1;
				r = x + 8'h01;
				vNew = (r == 8'h80);
			end
			OP_COUNT_DOWN: begin
				logicF = 1'b1;
				r = x - 8'h01;
				vNew = (r == 8'h7F);
			end
			OP_FILL_ONES: r = MASK_ALL;
			default: wb = 1'b0;
		endcase
		if (arith) begin
			if (sub) begin
				wide = {1'b0, x} - {1'b0, y} - {8'h00, cin};
				nib = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
				vNew = (x[7] & ~y[7] & ~wide[7]) | (~x[7] & y[7] & wide[7]);
			end else begin
				wide = {1'b0, x} + {1'b0, y} + {8'h00, cin};
				nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
				vNew = (x[7] & y[7] & ~wide[7]) | (~x[7] & ~y[7] & wide[7]);
			end
			r = wide[7:0];
			f[FLG_C] = wide[8];
			f[FLG_H] = nib[4];
			f[FLG_Z] = (r == 8'h00) & (f[FLG_Z] | ~keepZ);
		end
		// logic ops touch zero, negative, overflow and sign only; carry and half stay, except that invert sets carry
		if (arith | logicF) begin
			if (!arith)
				f[FLG_Z] = (r == 8'h00);
			f[FLG_N] = r[7];
			f[FLG_V] = vNew;
			f[FLG_S] = r[7] ^ vNew;
		end
		aluOut.res = r;
		aluOut.flags = f;
		aluOut.wb = wb;
	end
endmodule : aluex_alu

// [tb/aluex_checker.sv]
// aluex_checker: bus timing assertions on the register port of aluex_core.
// assumes one ref_clk domain, async active-high rst, one instruction per INSTR write.
`timescale 1ns/1ns
module aluex_checker
	import aluex_pkg::*;
(
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              ref_clk,
	input wire logic              rst,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_writedata,
	input wire logic [3:0]        avs_byteenable,
	input wire logic [31:0]       avs_readdata,
	input wire logic              avs_waitrequest
);
	logic       instrAcc;
	logic [5:0] opNum;
	logic       wrFree;
	logic       wrHeld;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// an accepted instruction write, and whether a write would pass or wait now
	assign instrAcc = avs_write && !avs_waitrequest && avs_address == REG_INSTR && avs_byteenable == BE_ALL;
	assign opNum    = avs_writedata[5:0];
	assign wrFree   = !avs_write || !avs_waitrequest;
	assign wrHeld   = !avs_write || avs_waitrequest;

	a_read_first_wait: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("read answered at once");
	a_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("read waits too long");
	a_idle_no_wait: assert property (!avs_read && !avs_write |-> !avs_waitrequest) else $error("wait with no request");
	a_alu_one_cycle: assert property (instrAcc && opNum <= 6'h16 |=> wrFree)
		else $error("alu op longer than one cycle");
	a_jump_two_cycle: assert property (instrAcc && opNum == 6'h17 |=> wrHeld ##1 wrFree)
		else $error("jump cycle count wrong");
	a_call_three_cycle: assert property (instrAcc && opNum == 6'h18 |=> wrHeld [*2] ##1 wrFree)
		else $error("call cycle count wrong");
	a_return_four_cycle: assert property (instrAcc && (opNum == 6'h19 || opNum == 6'h1A) |=> wrHeld [*3] ##1 wrFree)
		else $error("return cycle count wrong");
	a_flow_two_max: assert property (instrAcc && opNum >= 6'h1B && opNum <= 6'h33 |=> ##1 wrFree)
		else $error("skip or branch over two cycles");
endmodule : aluex_checker

bind aluex_core aluex_checker chk_i (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// [tb/tb_top.sv]
// tb_top: random and corner tests of aluex_core through its Avalon-MM register port.
// assumes the register map, instruction layout and opcode numbers of aluex_pkg.
`timescale 1ns/1ns
module tb_top;
	import aluex_pkg::*;
	logic        ref_clk;
	logic        rst;
	logic [8:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	int          errors;
	int          checks;
	logic [7:0]  cor [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};

	aluex_core uut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// 125 MHz core clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic end_of_test();
		if (errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one transfer, called just after a rising edge; waitrequest and read data are taken at the rising edge
	// the strobes stay up until the next call replaces them, so calls run back to back with no gap
	task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= !wr;
		avs_write     <= wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 64) begin
				errors++;
				$display("CHECK FAILED at %0t: bus timeout", $time);
				end_of_test();
			end
			@(posedge ref_clk);
		end
		q = avs_readdata;
	endtask : bus

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	function automatic logic [8:0] ra(input logic [4:0] n);
		return REG_WREG_BASE + {2'b00, n, 2'b00};
	endfunction : ra

	// reference alu: returns {result, flags}; compares hand the operand back untouched
	function automatic logic [15:0] model(input logic [5:0] op, input logic [7:0] a, input logic [7:0] b,
			input logic [7:0] f);
		logic [8:0] t;
		logic [4:0] h;
		logic [7:0] x;
		logic [7:0] y;
		logic [7:0] n;
		logic       ch;
		logic       ci;
		n  = f;
		ch = op == 6'd4 || op == 6'd5 || op == 6'd21;
		ci = (ch || op == 6'd1) && f[FLG_C];
		x  = (op == 6'd12) ? 8'h00 : a;
		y  = (op == 6'd12) ? a : b;
		case (op)
			0, 1: begin
				t = {1'b0, x} + {1'b0, y} + 9'(ci);
				h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + 5'(ci);
				n[FLG_V] = x[7] == y[7] && t[7] != x[7];
			end
			2, 3, 4, 5, 12, 20, 21, 22: begin
				t = {1'b0, x} - {1'b0, y} - 9'(ci);
				h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - 5'(ci);
				n[FLG_V] = x[7] != y[7] && t[7] != x[7];
			end
			default: begin
				h = {f[FLG_H], 4'h0};
				n[FLG_V] = 1'b0;
				case (op)
					6, 7:     t = {f[FLG_C], a & b};
					8, 9, 13: t = {f[FLG_C], a | b};
					10:       t = {f[FLG_C], a ^ b};
					11:       t = {1'b1, ~a};
					14:       t = {f[FLG_C], a & ~b};
					15:       t = {f[FLG_C], a + 8'h01};
					16:       t = {f[FLG_C], a - 8'h01};
					18:       t = {f[FLG_C], 8'h00};
					19:       t = {f[FLG_C], 8'hFF};
					default:  t = {f[FLG_C], a};
				endcase
				if (op == 6'd15) n[FLG_V] = t[7:0] == 8'h80;
				if (op == 6'd16) n[FLG_V] = t[7:0] == 8'h7F;
			end
		endcase
		n[FLG_C] = t[8];
		n[FLG_H] = h[4];
		n[FLG_Z] = t[7:0] == 8'h00 && (!ch || f[FLG_Z]);
		n[FLG_N] = t[7];
		n[FLG_S] = t[7] ^ n[FLG_V];
		if (op == 6'd19) n = f;
		return {(op >= 6'd20) ? a : t[7:0], n};
	endfunction : model

	// immediate k carries the same byte as register rr, so both operand forms see b
	task automatic alu_case(input int i);
		logic [5:0]  op;
		logic [4:0]  d;
		logic [4:0]  s;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [7:0]  f;
		logic [15:0] e;
		logic [31:0] q;
		op = 6'($urandom_range(22));
		d  = 5'($urandom);
		s  = d + 5'($urandom_range(31, 1));
		a  = (i < 16) ? cor[i % 4] : 8'($urandom);
		b  = (i < 16) ? cor[i / 4] : 8'($urandom);
		f  = 8'($urandom);
		wr(ra(d), {24'h0, a});
		wr(ra(s), {24'h0, b});
		wr(REG_FLAGS, {24'h0, f});
		wr(REG_INSTR, {1'b0, 3'h0, 4'h0, b, s, d, op});
		wr(REG_IOBITS, {24'h0, f});
		e = model(op, a, b, f);
		bus(1'b0, ra(d), 32'h0, q);
		chk(q, {24'h0, e[15:8]});
		bus(1'b0, REG_FLAGS, 32'h0, q);
		chk(q, {24'h0, e[7:0]});
	endtask : alu_case

	// one jump, call, return, skip or branch from a random machine state
	task automatic flow_case(input logic [5:0] op, input int i);
		logic [8:0]  p;
		logic [8:0]  np;
		logic [8:0]  s;
		logic [11:0] k;
		logic [7:0]  f;
		logic [7:0]  io;
		logic [7:0]  x;
		logic [7:0]  y;
		logic [2:0]  bs;
		logic [2:0]  cy;
		logic [4:0]  d;
		logic        v;
		logic        tk;
		logic [31:0] q;
		p  = 9'($urandom);
		s  = 9'($urandom);
		k  = (i == 0) ? 12'hFFF : 12'($urandom);
		f  = 8'($urandom);
		io = 8'($urandom);
		x  = 8'($urandom);
		y  = (i == 1) ? x : 8'($urandom);
		bs = 3'($urandom);
		d  = 5'($urandom);
		wr(ra(d), {24'h0, x});
		wr(ra(d + 5'd1), {24'h0, y});
		wr(REG_FLAGS, {24'h0, f});
		wr(REG_IOBITS, {24'h0, io});
		wr(REG_PC, {23'h0, p});
		wr(REG_STACK, {23'h0, s});
		wr(REG_INSTR, {1'b0, bs, k, d + 5'd1, d, op});
		// a write right behind the instruction must wait out its extra cycles
		wr(REG_IOBITS, {24'h0, io});
		v = 1'b0;
		case (op)
			27:     v = x != y;
			28, 29: v = !y[bs];
			30, 31: v = !io[bs];
			32, 33: v = f[bs];
			34, 35: v = f[FLG_Z];
			36, 37: v = f[FLG_C];
			38, 39: v = !f[FLG_C];
			40, 41: v = f[FLG_N];
			42, 43: v = !(f[FLG_N] ^ f[FLG_V]);
			44, 45: v = f[FLG_H];
			46, 47: v = f[FLG_T];
			48, 49: v = f[FLG_V];
			50, 51: v = f[FLG_I];
			default: v = 1'b0;
		endcase
		tk = op[0] ? !v : v;
		np = p + 9'd1;
		cy = 3'd1;
		if (op == 6'd23 || op == 6'd24) begin
			np = p + k[8:0] + 9'd1;
			cy = (op == 6'd23) ? 3'd2 : 3'd3;
		end else if (op == 6'd25 || op == 6'd26) begin
			np = s;
			cy = 3'd4;
		end else if (tk) begin
			np = (op < 6'd32) ? p + 9'd2 : p + k[8:0] + 9'd1;
			cy = 3'd2;
		end
		bus(1'b0, REG_PC, 32'h0, q);
		chk(q, {23'h0, np});
		bus(1'b0, REG_EXEC, 32'h0, q);
		chk({27'h0, q[4:0]}, {27'h0, cy != 3'd1, cy, 1'b0});
		bus(1'b0, REG_FLAGS, 32'h0, q);
		chk(q, {24'h0, f | ((op == 6'd26) ? 8'h80 : 8'h00)});
		bus(1'b0, REG_STACK, 32'h0, q);
		if (op == 6'd24) chk(q, {23'h0, p + 9'd1});
	endtask : flow_case

	// reset, random alu traffic with corner operands, every flow opcode, one unmapped read
	initial begin
		logic [31:0] q;
		errors         = 0;
		checks         = 0;
		rst            = 1'b1;
		avs_address    = 9'h000;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = BE_ALL;
		void'($urandom(32'h0527));
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 300; i++) alu_case(i);
		for (int i = 0; i < 6; i++) begin
			for (int op = 23; op < 52; op++) flow_case(6'(op), i);
		end
		bus(1'b0, 9'h018, 32'h0, q);
		chk(q, 32'h0);
		end_of_test();
	end
endmodule : tb_top
